// [hdl/fault_pin_mask_logic.sv]
// Fault flags, per-source gates and the active-low fault pin
`default_nettype none
module fault_pin_mask_logic
    import fault_gate_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    // Serial register link
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    // Analog detector levels, asynchronous
    input  wire logic       boost_uv_det_i,
    input  wire logic       boost_ov_det_i,
    input  wire logic       short_gnd_det_i,
    input  wire logic       src_boost_uv_det_i,
    input  wire logic       lower_src_uv_det_i,
    input  wire logic       pos_gate_uv_det_i,
    input  wire logic       neg_gate_uv_det_i,
    input  wire logic       heat_warn_det_i,
    // Fault pin
    output var  logic       fault_out_n_o,
    // Converter controls
    output var  logic       fast_start_o,
    output var  logic [5:0] soft_start_ms_o,
    output var  logic [10:0] ovp_final_mv_o,
    output var  logic [10:0] boost_ilim_ma_o,
    output var  logic [10:0] inv_ilim_ma_o,
    output var  logic [7:0] upper_rail_code_o,
    output var  logic [3:0] rail_off_o
);
    logic       rst_meta, rst_n;
    logic [7:0] det_meta, det_sync;
    logic [7:0] gate_primary, next_gate_primary;
    logic       heat_gate, next_heat_gate;
    logic [1:0] gen_cfg, next_gen_cfg;
    logic [7:0] upper_rail, next_upper_rail;
    logic [7:0] flags, next_flags;
    logic [7:0] live;
    logic [7:0] ungated;
    logic       heat_flag;
    logic       wr_stb, rd_stb;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic [16:0] tick_cnt, next_tick_cnt;
    logic       tick, next_tick;
    logic [5:0] uv_ms [4];
    logic [5:0] next_uv_ms [4];
    logic [3:0] next_rail_off;
    logic       next_fault_n;
    logic [3:0] rail_uv;

    // Reset release through two flops
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    serial_target u_target (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe_n_o (sda_oe_n_o),
        .wr_stb_o   (wr_stb),
        .wr_addr_o  (wr_addr),
        .wr_data_o  (wr_data),
        .rd_stb_o   (rd_stb),
        .rd_addr_o  (rd_addr),
        .rd_data_i  (rd_data)
    );

    // Detector bits in flag order; bit 3 carries heat warning
    assign live = {boost_uv_det_i, boost_ov_det_i, short_gnd_det_i,
                   src_boost_uv_det_i, heat_warn_det_i,
                   lower_src_uv_det_i, pos_gate_uv_det_i,
                   neg_gate_uv_det_i};
    assign heat_flag = det_sync[SOFT_START_BIT];
    assign rail_uv = {det_sync[SRC_BOOST_BIT], det_sync[LOWER_SRC_BIT],
                      det_sync[POS_GATE_BIT], det_sync[NEG_GATE_BIT]};

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (rd_addr)
            GEN_CFG_ADDR:      rd_data = {6'h00, gen_cfg};
            UPPER_RAIL_ADDR:   rd_data = upper_rail;
            FAULT_FLAGS_ADDR:  rd_data = flags & GATED_FLAGS;
            DEV_STATUS_ADDR:   rd_data = {6'h00, heat_flag, 1'b0};
            GATE_PRIMARY_ADDR: rd_data = gate_primary;
            GATE_THERMAL_ADDR: rd_data = {6'h00, heat_gate, 1'b0};
            default:           rd_data = 8'h00;
        endcase
    end

    // Writable registers
    always_comb begin
        next_gate_primary = gate_primary;
        next_heat_gate    = heat_gate;
        next_gen_cfg      = gen_cfg;
        next_upper_rail   = upper_rail;
        if (wr_stb) begin
            unique case (wr_addr)
                GATE_PRIMARY_ADDR: next_gate_primary = wr_data;
                GATE_THERMAL_ADDR: next_heat_gate = wr_data[HEAT_WARN_BIT];
                GEN_CFG_ADDR:      next_gen_cfg = wr_data[1:0];
                UPPER_RAIL_ADDR:   next_upper_rail = wr_data;
                default:           ;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            gate_primary <= GATE_PRIMARY_RST;
            heat_gate    <= GATE_THERMAL_RST[HEAT_WARN_BIT];
            gen_cfg      <= GEN_CFG_RST[1:0];
            upper_rail   <= UPPER_RAIL_RST;
        end else begin
            gate_primary <= next_gate_primary;
            heat_gate    <= next_heat_gate;
            gen_cfg      <= next_gen_cfg;
            upper_rail   <= next_upper_rail;
        end
    end

    // Latched flags: set on detection, cleared by reading them.
    // Set beats the clear so an event during the read survives.
    always_comb begin
        next_flags = flags;
        if (rd_stb && rd_addr == FAULT_FLAGS_ADDR) begin
            next_flags = 8'h00;
        end
        next_flags = (next_flags | det_sync) & GATED_FLAGS;
    end

    // Millisecond tick for the undervoltage persistence timers
    always_comb begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 17'd1;
        if (tick_cnt == 17'(TICK_LEN - 1)) begin
            next_tick_cnt = 17'd0;
            next_tick     = 1'b1;
        end
    end

    // Counts whole ticks, so turn-off lands between 50 and 51 ms
    always_comb begin
        next_rail_off = rail_off_o;
        for (int i = 0; i < 4; i++) begin
            next_uv_ms[i] = uv_ms[i];
            if (!rail_uv[i]) begin
                next_uv_ms[i] = 6'd0;
            end else if (tick && uv_ms[i] <= 6'(UV_OFF_MS)) begin
                next_uv_ms[i] = uv_ms[i] + 6'd1;
            end
            if (uv_ms[i] > 6'(UV_OFF_MS)) begin
                next_rail_off[i] = 1'b1;
            end
        end
    end

    // Pin is low while any ungated flag stands
    always_comb begin
        ungated      = flags & ~gate_primary & GATED_FLAGS;
        next_fault_n = ~|ungated;
        if (heat_flag && !heat_gate) begin
            next_fault_n = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            det_meta          <= 8'h00;
            det_sync          <= 8'h00;
            flags             <= 8'h00;
            tick_cnt          <= 17'd0;
            tick              <= 1'b0;
            uv_ms             <= '{default: 6'd0};
            rail_off_o        <= 4'h0;
            fault_out_n_o     <= 1'b1;
            fast_start_o      <= 1'b0;
            soft_start_ms_o   <= SS_STD_MS;
            ovp_final_mv_o    <= SS_STD_MV;
            boost_ilim_ma_o   <= BOOST_LIM_HI_MA;
            inv_ilim_ma_o     <= INV_LIM_HI_MA;
            upper_rail_code_o <= UPPER_RAIL_RST;
        end else begin
            det_meta          <= live;
            det_sync          <= det_meta;
            flags             <= next_flags;
            tick_cnt          <= next_tick_cnt;
            tick              <= next_tick;
            uv_ms             <= next_uv_ms;
            rail_off_o        <= next_rail_off;
            fault_out_n_o     <= next_fault_n;
            fast_start_o      <= gate_primary[SOFT_START_BIT];
            soft_start_ms_o   <= gate_primary[SOFT_START_BIT]
                                 ? SS_FAST_MS : SS_STD_MS;
            ovp_final_mv_o    <= gate_primary[SOFT_START_BIT]
                                 ? SS_FAST_MV : SS_STD_MV;
            boost_ilim_ma_o   <= gen_cfg[BOOST_LIM_BIT]
                                 ? BOOST_LIM_LO_MA : BOOST_LIM_HI_MA;
            inv_ilim_ma_o     <= gen_cfg[INV_LIM_BIT]
                                 ? INV_LIM_LO_MA : INV_LIM_HI_MA;
            upper_rail_code_o <= upper_rail;
        end
    end
endmodule // fault_pin_mask_logic
`default_nettype wire

// [hdl/serial_target.sv]
// Byte-level serial register target on an oversampled two-wire link
`default_nettype none
module serial_target
    import fault_gate_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Link pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_n_o,
    // Register side
    output var  logic       wr_stb_o,
    output var  logic [7:0] wr_addr_o,
    output var  logic [7:0] wr_data_o,
    output var  logic       rd_stb_o,
    output logic      [7:0] rd_addr_o,
    input  wire logic [7:0] rd_data_i
);
    logic [1:0] scl_meta, sda_meta;
    logic       scl_q, sda_q;
    serial_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg, ptr, next_ptr;
    logic       rw, next_rw, next_oe_n, next_wr, next_rd;
    logic [7:0] next_wr_addr, next_wr_data;
    logic       rise, fall, start, stop;

    assign rd_addr_o = ptr;
    assign rise  = scl_meta[1] & ~scl_q;
    assign fall  = ~scl_meta[1] & scl_q;
    assign start = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
    assign stop  = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];

    always_comb begin
        next_state   = state;
        // Advance after the strobe, so it shows the byte's own address
        if (rd_stb_o) begin
            next_ptr = ptr + 8'h01;
        end
        next_cnt     = cnt;
        next_shreg   = shreg;
        next_rw      = rw;
        if (!rd_stb_o) begin
            next_ptr = ptr;
        end
        next_oe_n    = sda_oe_n_o;
        next_wr      = 1'b0;
        next_rd      = 1'b0;
        next_wr_addr = wr_addr_o;
        next_wr_data = wr_data_o;
        if (start) begin
            next_state = S_ADDR;
            next_cnt   = 4'h0;
            next_oe_n  = 1'b1;
        end else if (stop) begin
            next_state = S_IDLE;
            next_oe_n  = 1'b1;
        end else begin
            unique case (state)
                S_IDLE: begin
                    next_oe_n = 1'b1;
                end
                S_ADDR, S_REG, S_WDATA: begin
                    if (rise) begin
                        next_shreg = {shreg[6:0], sda_meta[1]};
                        next_cnt   = cnt + 4'h1;
                    end else if (fall && cnt == 4'h8) begin
                        next_oe_n = 1'b0;
                        if (state == S_ADDR) begin
                            next_rw    = shreg[0];
                            next_state = S_ACK_ADDR;
                            if (shreg[7:1] != TARGET_ADDR) begin
                                next_oe_n  = 1'b1;
                                next_state = S_IDLE;
                            end
                        end else if (state == S_REG) begin
                            next_ptr   = shreg;
                            next_state = S_ACK_REG;
                        end else begin
                            next_wr      = 1'b1;
                            next_wr_addr = ptr;
                            next_wr_data = shreg;
                            next_ptr     = ptr + 8'h01;
                            next_state   = S_ACK_W;
                        end
                    end
                end
                S_ACK_ADDR, S_ACK_REG, S_ACK_W, S_RACK: begin
                    if (state == S_RACK && rise && sda_meta[1]) begin
                        // Host refused more data
                        next_state = S_IDLE;
                    end else if (fall) begin
                        next_cnt  = 4'h0;
                        next_oe_n = 1'b1;
                        if ((state == S_ACK_ADDR && rw) || state == S_RACK) begin
                            next_shreg = rd_data_i;
                            next_oe_n  = rd_data_i[7];
                            next_rd    = 1'b1;
                            next_state = S_RDATA;
                        end else if (state == S_ACK_ADDR) begin
                            next_state = S_REG;
                        end else begin
                            next_state = S_WDATA;
                        end
                    end
                end
                S_RDATA: begin
                    if (rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (fall && cnt == 4'h8) begin
                        next_oe_n  = 1'b1;
                        next_state = S_RACK;
                    end else if (fall) begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_oe_n  = shreg[6];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_meta   <= 2'b11;
            sda_meta   <= 2'b11;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            state      <= S_IDLE;
            cnt        <= 4'h0;
            shreg      <= 8'h00;
            ptr        <= 8'h00;
            rw         <= 1'b0;
            sda_o      <= 1'b0;
            sda_oe_n_o <= 1'b1;
            wr_stb_o   <= 1'b0;
            rd_stb_o   <= 1'b0;
            wr_addr_o  <= 8'h00;
            wr_data_o  <= 8'h00;
        end else begin
            scl_meta   <= {scl_meta[0], scl_i};
            sda_meta   <= {sda_meta[0], sda_i};
            scl_q      <= scl_meta[1];
            sda_q      <= sda_meta[1];
            state      <= next_state;
            cnt        <= next_cnt;
            shreg      <= next_shreg;
            ptr        <= next_ptr;
            rw         <= next_rw;
            sda_o      <= 1'b0;
            sda_oe_n_o <= next_oe_n;
            wr_stb_o   <= next_wr;
            rd_stb_o   <= next_rd;
            wr_addr_o  <= next_wr_addr;
            wr_data_o  <= next_wr_data;
        end
    end
endmodule // serial_target
`default_nettype wire

// [inc/fault_gate_pkg.sv]
// Constants and types shared by the fault gate and its serial target
//
// Functional notes
// - Bit 7 mask blocks boost undervoltage from pin
// - Bit 6 mask blocks boost overvoltage from pin
// - Bit 5 mask blocks LED short-to-ground from pin
// - Bit 4 mask blocks source-boost undervoltage from pin
// - Bit 3 picks 50ms/0.6V or 22ms/1.1V start
// - Bit 2 mask blocks lower source undervoltage
// - Bit 1 mask blocks positive gate undervoltage
// - Bit 0 mask blocks negative gate undervoltage
// - Second register bit 1 masks heat warning
// - Config bit picks boost limit 1.7A/0.74A
// - Config bit picks inverter limit 1.2A/0.6A
// - Host writes 8-bit upper rail code at 0x03
// - Rail undervoltage flags immediate; 50ms turns off
// - Heat warning reads 1 at/above 125 C
`default_nettype none
package fault_gate_pkg;
    // Register offsets
    localparam logic [7:0] GEN_CFG_ADDR      = 8'h01;
    localparam logic [7:0] UPPER_RAIL_ADDR   = 8'h03;
    localparam logic [7:0] FAULT_FLAGS_ADDR  = 8'h08;
    localparam logic [7:0] DEV_STATUS_ADDR   = 8'h09;
    localparam logic [7:0] GATE_PRIMARY_ADDR = 8'h0b;
    localparam logic [7:0] GATE_THERMAL_ADDR = 8'h0c;
    // Field positions
    localparam int BOOST_UV_BIT   = 7;
    localparam int BOOST_OV_BIT   = 6;
    localparam int SHORT_GND_BIT  = 5;
    localparam int SRC_BOOST_BIT  = 4;
    localparam int SOFT_START_BIT = 3;
    localparam int LOWER_SRC_BIT  = 2;
    localparam int POS_GATE_BIT   = 1;
    localparam int NEG_GATE_BIT   = 0;
    localparam int HEAT_WARN_BIT  = 1;
    localparam int BOOST_LIM_BIT  = 1;
    localparam int INV_LIM_BIT    = 0;
    // Values after reset
    localparam logic [7:0] GATE_PRIMARY_RST = 8'h00;
    localparam logic [7:0] GATE_THERMAL_RST = 8'h00;
    localparam logic [7:0] GEN_CFG_RST      = 8'h00;
    localparam logic [7:0] UPPER_RAIL_RST   = 8'h00;
    // Flags that have a gate bit
    localparam logic [7:0] GATED_FLAGS = 8'hf7;
    // Soft-start choices, in ms and mV on the overvoltage sense input
    localparam logic [5:0]  SS_STD_MS   = 6'd50;
    localparam logic [5:0]  SS_FAST_MS  = 6'd22;
    localparam logic [10:0] SS_STD_MV   = 11'd600;
    localparam logic [10:0] SS_FAST_MV  = 11'd1100;
    // Current limits in mA
    localparam logic [10:0] BOOST_LIM_HI_MA = 11'd1700;
    localparam logic [10:0] BOOST_LIM_LO_MA = 11'd740;
    localparam logic [10:0] INV_LIM_HI_MA   = 11'd1200;
    localparam logic [10:0] INV_LIM_LO_MA   = 11'd600;
    // Timing
    localparam int CLK_HZ         = 100_000_000;
    localparam int TICK_US        = 1000;
    localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
    localparam int UV_OFF_MS      = 50;
    localparam int HEAT_WARN_DEGC = 125;
    // Serial target address, arbitrary value
    localparam logic [6:0] TARGET_ADDR = 7'h2a;

    typedef enum logic [8:0] {
        S_IDLE     = 9'b000000001,
        S_ADDR     = 9'b000000010,
        S_ACK_ADDR = 9'b000000100,
        S_REG      = 9'b000001000,
        S_ACK_REG  = 9'b000010000,
        S_WDATA    = 9'b000100000,
        S_ACK_W    = 9'b001000000,
        S_RDATA    = 9'b010000000,
        S_RACK     = 9'b100000000
    } serial_state_t;
endpackage
`default_nettype wire

// [verif/fault_gate_props.sv]
// Port-level checks on the fault gate
`default_nettype none
module fault_gate_props
    import fault_gate_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)(
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    // Watched inputs
    input wire logic        scl_i,
    input wire logic        src_boost_uv_det_i,
    input wire logic        lower_src_uv_det_i,
    input wire logic        pos_gate_uv_det_i,
    input wire logic        neg_gate_uv_det_i,
    // Watched outputs
    input wire logic        fault_out_n_o,
    input wire logic        fast_start_o,
    input wire logic [5:0]  soft_start_ms_o,
    input wire logic [10:0] ovp_final_mv_o,
    input wire logic [10:0] boost_ilim_ma_o,
    input wire logic [10:0] inv_ilim_ma_o,
    input wire logic [7:0]  upper_rail_code_o,
    input wire logic [3:0]  rail_off_o
);
    // Slack covers input sync, internal reset and tick phase
    localparam int EARLY = 50 * TICK_LEN - 8;
    localparam int LATE  = 51 * TICK_LEN + 12;
    logic [3:0] det;
    logic [3:0] early;
    logic [3:0] late;
    int         run      [4];
    int         next_run [4];

    assign det = {src_boost_uv_det_i, lower_src_uv_det_i,
                  pos_gate_uv_det_i, neg_gate_uv_det_i};

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            next_run[k] = det[k] ? run[k] + 1 : 0;
            early[k]    = run[k] >= EARLY;
            late[k]     = run[k] >= LATE;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run <= '{default: 0};
        end else begin
            run <= next_run;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_release;
        $rose(arst_n_i);
    endsequence

    a_fast_start_pair: assert property (fast_start_o |->
        soft_start_ms_o == SS_FAST_MS && ovp_final_mv_o == SS_FAST_MV)
        else $error("fast start figures wrong");
    a_std_start_pair: assert property (!fast_start_o |->
        soft_start_ms_o == SS_STD_MS && ovp_final_mv_o == SS_STD_MV)
        else $error("standard start figures wrong");
    a_boost_limit_set: assert property (boost_ilim_ma_o ==
        BOOST_LIM_HI_MA || boost_ilim_ma_o == BOOST_LIM_LO_MA)
        else $error("boost limit off the two settings");
    a_inv_limit_set: assert property (inv_ilim_ma_o ==
        INV_LIM_HI_MA || inv_ilim_ma_o == INV_LIM_LO_MA)
        else $error("inverter limit off the two settings");
    a_code_after_clock: assert property ($changed(upper_rail_code_o)
        |-> !$past(scl_i, 3)) else $error("rail code moved off a write");
    a_rail_not_early: assert property ((rail_off_o &
        ~$past(rail_off_o) & ~$past(early, 4)) == 4'h0)
        else $error("rail turned off too soon");
    a_rail_by_deadline: assert property ((late & ~rail_off_o)
        == 4'h0) else $error("rail not turned off in time");
    a_rail_off_sticky: assert property (($past(rail_off_o)
        & ~rail_off_o) == 4'h0) else $error("rail off bit dropped");
    a_pin_quiet_release: assert property (s_release |->
        fault_out_n_o [*3]) else $error("fault pin low at release");
endmodule // fault_gate_props

bind fault_pin_mask_logic fault_gate_props #(.TICK_LEN(TICK_LEN)) i_props (.*);
`default_nettype wire

// [verif/serial_host_model.sv]
// Two-wire register host driving the fault gate's serial link
`default_nettype none
module serial_host_model
    import fault_gate_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Ten clocks a phase, above the eight-clock minimum
    task automatic phase(input logic c, input logic d);
        @(posedge clock_i);
        scl_o <= c;
        sda_o <= d;
        repeat (9) @(posedge clock_i);
    endtask

    // Data moves only while the clock line is low
    task automatic bit_io(input logic d, output logic q);
        phase(1'b0, d);
        phase(1'b1, d);
        q = sda_i;
        phase(1'b0, d);
    endtask

    task automatic byte_io(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask

    task automatic start_cond;
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b0);
    endtask

    task automatic stop_cond;
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                             output logic ok);
        logic [7:0] q;
        logic [2:0] k;
        start_cond;
        byte_io({TARGET_ADDR, 1'b0}, 1'b1, q, k[0]);
        byte_io(a, 1'b1, q, k[1]);
        byte_io(d, 1'b1, q, k[2]);
        stop_cond;
        ok = k == 3'h0;
    endtask

    // One byte read, ended by a host refusal
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        logic [7:0] q;
        logic [3:0] k;
        start_cond;
        byte_io({TARGET_ADDR, 1'b0}, 1'b1, q, k[0]);
        byte_io(a, 1'b1, q, k[1]);
        start_cond;
        byte_io({TARGET_ADDR, 1'b1}, 1'b1, q, k[2]);
        byte_io(8'hff, 1'b1, d, k[3]);
        stop_cond;
        ok = k[2:0] == 3'h0;
    endtask
endmodule // serial_host_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the fault gate
`default_nettype none
module tb_top;
    import fault_gate_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TL = 10;
    logic        clock_i  = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [7:0]  det      = 8'h00;
    logic        scl_i;
    logic        host_sda;
    logic        sda_o;
    logic        sda_oe_n_o;
    logic        fault_out_n_o;
    logic        fast_start_o;
    logic [5:0]  soft_start_ms_o;
    logic [10:0] ovp_final_mv_o;
    logic [10:0] boost_ilim_ma_o;
    logic [10:0] inv_ilim_ma_o;
    logic [7:0]  upper_rail_code_o;
    logic [3:0]  rail_off_o;
    logic [7:0]  rv;
    logic        ok;
    int          mismatches  = 0;
    int          comparisons = 0;
    // Pull-up on the data line; the device only pulls low
    wire logic   sda_i = sda_oe_n_o ? host_sda : 1'b0;

    always #5 clock_i = ~clock_i;

    fault_pin_mask_logic #(.TICK_LEN(TL)) i_dut (
        .clock_i, .arst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
        .boost_uv_det_i(det[7]), .boost_ov_det_i(det[6]),
        .short_gnd_det_i(det[5]), .src_boost_uv_det_i(det[4]),
        .heat_warn_det_i(det[3]), .lower_src_uv_det_i(det[2]),
        .pos_gate_uv_det_i(det[1]), .neg_gate_uv_det_i(det[0]),
        .fault_out_n_o, .fast_start_o, .soft_start_ms_o, .ovp_final_mv_o,
        .boost_ilim_ma_o, .inv_ilim_ma_o, .upper_rail_code_o, .rail_off_o
    );
    serial_host_model i_host (
        .clock_i, .sda_i, .scl_o(scl_i), .sda_o(host_sda)
    );

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_pin(input logic lvl);
        for (int n = 0; n < 20 && fault_out_n_o !== lvl; n++) begin
            @(negedge clock_i);
        end
        if (fault_out_n_o !== lvl) begin
            mismatches++;
            $display("[ERR] %0t ns: fault pin stuck", $time);
            tally_and_finish;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.write_reg(a, d, ok);
        check(ok, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a);
        i_host.read_reg(a, rv, ok);
        check(ok, 1'b1);
    endtask

    task automatic t_reset;
        check(fault_out_n_o, 1'b1);
        check(upper_rail_code_o, UPPER_RAIL_RST);
        check(rail_off_o, 4'h0);
        rd(GATE_PRIMARY_ADDR);
        check(rv, GATE_PRIMARY_RST);
        rd(GATE_THERMAL_ADDR);
        check(rv, GATE_THERMAL_RST);
    endtask

    task automatic t_gates;
        for (int i = 0; i < 8; i++) begin
            if (i == SOFT_START_BIT) continue;
            wr(GATE_PRIMARY_ADDR, 8'h01 << i);
            @(posedge clock_i) det[i] <= 1'b1;
            repeat (8) @(negedge clock_i);
            check(fault_out_n_o, 1'b1);
            @(posedge clock_i) det[i] <= 1'b0;
            // All other gates set: a wrong bit map shows here
            wr(GATE_PRIMARY_ADDR, ~(8'h01 << i));
            wait_pin(1'b0);
            check(fault_out_n_o, 1'b0);
            rd(FAULT_FLAGS_ADDR);
            check(rv, 8'h01 << i);
            wait_pin(1'b1);
            check(fault_out_n_o, 1'b1);
        end
        wr(GATE_PRIMARY_ADDR, 8'h00);
    endtask

    task automatic t_heat;
        wr(GATE_THERMAL_ADDR, 8'hff);
        rd(GATE_THERMAL_ADDR);
        check(rv, 8'h02);
        @(posedge clock_i) det[3] <= 1'b1;
        repeat (8) @(negedge clock_i);
        check(fault_out_n_o, 1'b1);
        rd(DEV_STATUS_ADDR);
        check(rv[HEAT_WARN_BIT], 1'b1);
        wr(GATE_THERMAL_ADDR, 8'h00);
        wait_pin(1'b0);
        check(fault_out_n_o, 1'b0);
        @(posedge clock_i) det[3] <= 1'b0;
        wait_pin(1'b1);
        check(fault_out_n_o, 1'b1);
    endtask

    task automatic t_config;
        logic [10:0] eb;
        logic [10:0] ei;
        wr(GATE_PRIMARY_ADDR, 8'h08);
        check(fast_start_o, 1'b1);
        check(soft_start_ms_o, SS_FAST_MS);
        check(ovp_final_mv_o, SS_FAST_MV);
        wr(GATE_PRIMARY_ADDR, 8'h00);
        check(soft_start_ms_o, SS_STD_MS);
        check(ovp_final_mv_o, SS_STD_MV);
        for (int c = 0; c < 4; c++) begin
            wr(GEN_CFG_ADDR, 8'(c));
            eb = c[1] ? BOOST_LIM_LO_MA : BOOST_LIM_HI_MA;
            ei = c[0] ? INV_LIM_LO_MA : INV_LIM_HI_MA;
            check(boost_ilim_ma_o, eb);
            check(inv_ilim_ma_o, ei);
        end
        wr(UPPER_RAIL_ADDR, 8'ha5);
        check(upper_rail_code_o, 8'ha5);
        rd(UPPER_RAIL_ADDR);
        check(rv, 8'ha5);
        rd(8'h20);
        check(rv, 8'h00);
    endtask

    // A short dip must restart the persistence count
    task automatic t_rail;
        @(posedge clock_i) det[2] <= 1'b1;
        repeat (40 * TL) @(posedge clock_i);
        det[2] <= 1'b0;
        repeat (5) @(posedge clock_i);
        det[2] <= 1'b1;
        repeat (49 * TL) @(negedge clock_i);
        check(rail_off_o, 4'h0);
        repeat (4 * TL) @(negedge clock_i);
        check(rail_off_o, 4'b0100);
        @(posedge clock_i) det[2] <= 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        @(negedge clock_i);
        t_reset;
        t_gates;
        t_heat;
        t_config;
        t_rail;
        tally_and_finish;
    end

    initial begin
        repeat (100000) @(posedge clock_i);
        mismatches++;
        $display("[ERR] %0t ns: run too long", $time);
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
